// ==== dpo_pkg.sv ====
// Package for the drive parameter object bank: offsets, reset values, field positions
`default_nettype none

package dpo_pkg;
   // Register byte offsets (one word each; all aligned except OFS_ANALOG_MODE at 3221)
   localparam logic [15:0] OFS_TQ_P_CLOSED  = 16'h0000;
   localparam logic [15:0] OFS_TQ_I_CLOSED  = 16'h0004;
   localparam logic [15:0] OFS_CUR_P_OPEN   = 16'h0008;
   localparam logic [15:0] OFS_CUR_I_OPEN   = 16'h000c;
   localparam logic [15:0] OFS_SPEED_FF     = 16'h0010;
   localparam logic [15:0] OFS_ACCEL_FF     = 16'h0014;
   localparam logic [15:0] OFS_FLAGS_COUNT  = 16'h0018;
   localparam logic [15:0] OFS_FLAGS_SPARE  = 16'h001c;
   localparam logic [15:0] OFS_FIELD_INV    = 16'h0020;
   localparam logic [15:0] OFS_PRESERVE     = 16'h0024;
   localparam logic [15:0] OFS_AIN_COUNT    = 16'h0028;
   localparam logic [15:0] OFS_AIN_ONE      = 16'h002c;
   localparam logic [15:0] OFS_AIN_TWO      = 16'h0030;
   localparam logic [15:0] OFS_SW_COUNT     = 16'h0034;
   localparam logic [15:0] OFS_SW_POS       = 16'h0038;
   localparam logic [15:0] OFS_FIELD_ACTIVE = 16'h003c;
   localparam logic [15:0] OFS_ANALOG_MODE  = 16'h3221;

   // Reset values
   localparam logic [31:0] RST_TQ_P_CLOSED = 32'h000668a0;
   localparam logic [31:0] RST_TQ_I_CLOSED = 32'h00002ee0;
   localparam logic [31:0] RST_CUR_P_OPEN  = 32'h0003a980;
   localparam logic [31:0] RST_CUR_I_OPEN  = 32'h0000afc8;
   localparam logic [31:0] RST_SPEED_FF    = 32'h000003e8;
   localparam logic [31:0] RST_ACCEL_FF    = 32'h00000000;
   localparam logic [7:0]  RST_FLAGS_COUNT = 8'h03;
   localparam logic [7:0]  RST_FIELD_INV   = 8'h00;
   localparam logic [7:0]  RST_PRESERVE    = 8'h00;
   localparam logic [7:0]  RST_AIN_COUNT   = 8'h02;
   localparam logic [7:0]  RST_SW_COUNT    = 8'h01;
   localparam logic [31:0] RST_ANALOG_MODE = 32'h00000000;

   // Field inversion codes (signed 8-bit)
   localparam logic [7:0]  INV_DEFAULT = 8'h00;
   localparam logic [7:0]  INV_FORCE_POS = 8'h01;
   localparam logic [7:0]  INV_FORCE_NEG = 8'hff;

   // Field positions of the analog mode word
   localparam int AIN_ONE_CUR_BIT = 0;
   localparam int AIN_TWO_CUR_BIT = 1;

   // Analog scaling: full scale digits, 10 V or 20 mA
   localparam logic [15:0] AIN_FULL_SCALE = 16'h03ff;

   // Restart and auto setup sequencing states
   typedef enum logic [2:0]
   {
      DPO_IDLE   = 3'b001,
      DPO_SAMPLE = 3'b010,
      DPO_SETUP  = 3'b100
   } dpo_state_t;
endpackage : dpo_pkg

`default_nettype wire

// ==== dpo_bank.sv ====
// Drive parameter object bank: gain set, drive flags and analog input objects
//
// What this block does
// - Closed-loop torque current gains reset to P 000668a0 and I 00002ee0, both RW 32-bit.
// - Open-loop current gains reset to P 0003a980 and I 0000afc8, both RW 32-bit.
// - Speed feed-forward is in tenths of a percent; its reset 1000 means unity.
// - Acceleration feed-forward resets to zero (off) and, when nonzero, acts in both directions.
// - A new field inversion value only takes effect after a controller restart.
// - Inversion 0 uses firmware default, 1 forces positive field, -1 forces negative field.
// - With preserve flag 0, auto setup loads the preset set for the detected motor type.
// - With preserve flag 1, auto setup keeps the stored gains untouched.
// - Two read-only signed 16-bit analog values hold the instantaneous conversion results.
// - Analog scaling is 1023 digits for 10 V or, in current mode, 20 mA.
// - A cleared mode bit means voltage measurement, a set bit means current.
// - Mode bit 0 configures input 1, bit 1 configures input 2, other bits unused.
// - Current mode is only granted where that input's hardware supports it.
// - The switch position is sampled once at restart and held read-only.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module dpo_bank
(
   // Clock and reset
   input  wire  logic        clk_sys_in,
   input  wire  logic        rst_in,
   // Register port
   input  wire  logic [15:0] addr_in,
   input  wire  logic [31:0] wdata_in,
   input  wire  logic        wr_in,
   input  wire  logic        rd_in,
   output var   logic [31:0] rdata_out,
   // Controller restart and auto setup
   input  wire  logic        restart_in,
   input  wire  logic        autosetup_start_in,
   input  wire  logic        motor_is_stepper_in,
   // Preset gain sets offered by the firmware for the detected motor type
   input  wire  logic [31:0] stepper_tq_p_in,
   input  wire  logic [31:0] stepper_tq_i_in,
   input  wire  logic [31:0] bldc_tq_p_in,
   input  wire  logic [31:0] bldc_tq_i_in,
   // Analog front end
   input  wire  logic [15:0] ain_one_in,
   input  wire  logic [15:0] ain_two_in,
   input  wire  logic [1:0]  ain_current_capable_in,
   input  wire  logic [15:0] ain_switch_in,
   // Control outputs
   output var   logic        analog_one_current_select_out,
   output var   logic        analog_two_current_select_out,
   output var   logic [1:0]  field_dir_out,
   output var   logic        autosetup_busy_out,
   output var   logic [31:0] tq_p_gain_out,
   output var   logic [31:0] tq_i_gain_out,
   output var   logic [31:0] speed_ff_out,
   output var   logic        accel_ff_enable_out
);

   ////////////////////////////////////////////////////////////////////////////////
   // Register state
   logic [31:0]            tq_p_closed_ff;
   logic [31:0]            tq_i_closed_ff;
   logic [31:0]            cur_p_open_ff;
   logic [31:0]            cur_i_open_ff;
   logic [31:0]            speed_ff_ff;
   logic [31:0]            accel_ff_ff;
   logic [7:0]             spare_ff;
   logic [7:0]             field_inv_ff;
   logic [7:0]             field_active_ff;
   logic [7:0]             preserve_ff;
   logic [31:0]            analog_mode_ff;
   logic [15:0]            ain_one_ff;
   logic [15:0]            ain_two_ff;
   logic [15:0]            sw_pos_ff;
   dpo_pkg::dpo_state_t    state_ff;
   logic [31:0]            nxt_rdata;

   // Map an inversion code to a direction: 00 default, 01 positive, 10 negative
   function automatic logic [1:0] dpo_field_dir(input logic [7:0] code);
      logic [1:0] dir;
      dir = 2'b00;
      if (code == dpo_pkg::INV_FORCE_POS)
         dir = 2'b01;
      else if (code == dpo_pkg::INV_FORCE_NEG)
         dir = 2'b10;
      return dir;
   endfunction : dpo_field_dir

   // Write strobe decode for one offset
   function automatic logic dpo_hit(input logic [15:0] a, input logic [15:0] ofs);
      return a == ofs;
   endfunction : dpo_hit

   ////////////////////////////////////////////////////////////////////////////////
   // Restart and auto setup sequencing
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         state_ff <= dpo_pkg::DPO_IDLE;
      else
      begin
         unique case (state_ff)
            dpo_pkg::DPO_IDLE:
            begin
               if (restart_in)
                  state_ff <= dpo_pkg::DPO_SAMPLE;
               else if (autosetup_start_in)
                  state_ff <= dpo_pkg::DPO_SETUP;
            end
            dpo_pkg::DPO_SAMPLE:
               state_ff <= dpo_pkg::DPO_IDLE;
            dpo_pkg::DPO_SETUP:
               state_ff <= dpo_pkg::DPO_IDLE;
            default:
               state_ff <= dpo_pkg::DPO_IDLE;
         endcase
      end
   end

   // Switch sampled only in the single restart cycle; held otherwise
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         sw_pos_ff <= 16'h0000;
      else if (state_ff == dpo_pkg::DPO_SAMPLE)
         sw_pos_ff <= ain_switch_in;
   end

   // Inversion value becomes active only at restart, so a running field never flips
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         field_active_ff <= dpo_pkg::RST_FIELD_INV;
      else if (state_ff == dpo_pkg::DPO_SAMPLE)
         field_active_ff <= field_inv_ff;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Gain registers; auto setup reloads closed-loop torque gains unless preserved
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         tq_p_closed_ff <= dpo_pkg::RST_TQ_P_CLOSED;
         tq_i_closed_ff <= dpo_pkg::RST_TQ_I_CLOSED;
      end
      else if (state_ff == dpo_pkg::DPO_SETUP && preserve_ff == 8'h00)
      begin
         tq_p_closed_ff <= motor_is_stepper_in ? stepper_tq_p_in : bldc_tq_p_in;
         tq_i_closed_ff <= motor_is_stepper_in ? stepper_tq_i_in : bldc_tq_i_in;
      end
      else if (wr_in)
      begin
         if (dpo_hit(addr_in, dpo_pkg::OFS_TQ_P_CLOSED))
            tq_p_closed_ff <= wdata_in;
         if (dpo_hit(addr_in, dpo_pkg::OFS_TQ_I_CLOSED))
            tq_i_closed_ff <= wdata_in;
      end
   end

   // Open-loop gains and feed-forward terms: plain software registers
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         cur_p_open_ff <= dpo_pkg::RST_CUR_P_OPEN;
         cur_i_open_ff <= dpo_pkg::RST_CUR_I_OPEN;
         speed_ff_ff   <= dpo_pkg::RST_SPEED_FF;
         accel_ff_ff   <= dpo_pkg::RST_ACCEL_FF;
      end
      else if (wr_in)
      begin
         if (dpo_hit(addr_in, dpo_pkg::OFS_CUR_P_OPEN))
            cur_p_open_ff <= wdata_in;
         if (dpo_hit(addr_in, dpo_pkg::OFS_CUR_I_OPEN))
            cur_i_open_ff <= wdata_in;
         if (dpo_hit(addr_in, dpo_pkg::OFS_SPEED_FF))
            speed_ff_ff <= wdata_in;
         if (dpo_hit(addr_in, dpo_pkg::OFS_ACCEL_FF))
            accel_ff_ff <= wdata_in;
      end
   end

   // Drive flags and analog mode word
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         spare_ff       <= 8'h00;
         field_inv_ff   <= dpo_pkg::RST_FIELD_INV;
         preserve_ff    <= dpo_pkg::RST_PRESERVE;
         analog_mode_ff <= dpo_pkg::RST_ANALOG_MODE;
      end
      else if (wr_in)
      begin
         if (dpo_hit(addr_in, dpo_pkg::OFS_FLAGS_SPARE))
            spare_ff <= wdata_in[7:0];
         if (dpo_hit(addr_in, dpo_pkg::OFS_FIELD_INV))
            field_inv_ff <= wdata_in[7:0];
         if (dpo_hit(addr_in, dpo_pkg::OFS_PRESERVE))
            preserve_ff <= wdata_in[7:0];
         if (dpo_hit(addr_in, dpo_pkg::OFS_ANALOG_MODE))
            analog_mode_ff <= wdata_in;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Live analog conversion results, refreshed every cycle
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         ain_one_ff <= 16'h0000;
         ain_two_ff <= 16'h0000;
      end
      else
      begin
         ain_one_ff <= ain_one_in;
         ain_two_ff <= ain_two_in;
      end
   end

   // Current mode granted only where the hardware can measure current
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         analog_one_current_select_out <= 1'b0;
         analog_two_current_select_out <= 1'b0;
      end
      else
      begin
         analog_one_current_select_out <= analog_mode_ff[dpo_pkg::AIN_ONE_CUR_BIT]
                                          & ain_current_capable_in[0];
         analog_two_current_select_out <= analog_mode_ff[dpo_pkg::AIN_TWO_CUR_BIT]
                                          & ain_current_capable_in[1];
      end
   end

   // Control outputs; torque gain outputs always carry the closed-loop set, open-loop gains are not driven out
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
      begin
         field_dir_out       <= 2'b00;
         autosetup_busy_out  <= 1'b0;
         tq_p_gain_out       <= dpo_pkg::RST_TQ_P_CLOSED;
         tq_i_gain_out       <= dpo_pkg::RST_TQ_I_CLOSED;
         speed_ff_out        <= dpo_pkg::RST_SPEED_FF;
         accel_ff_enable_out <= 1'b0;
      end
      else
      begin
         field_dir_out       <= dpo_field_dir(field_active_ff);
         autosetup_busy_out  <= (state_ff == dpo_pkg::DPO_SETUP);
         tq_p_gain_out       <= tq_p_closed_ff;
         tq_i_gain_out       <= tq_i_closed_ff;
         speed_ff_out        <= speed_ff_ff;
         accel_ff_enable_out <= (accel_ff_ff != 32'h00000000);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read mux; scaling of analog digits (full scale 3ff) is done by software
   always_comb
   begin
      nxt_rdata = 32'h00000000;
      unique case (addr_in)
         dpo_pkg::OFS_TQ_P_CLOSED:  nxt_rdata = tq_p_closed_ff;
         dpo_pkg::OFS_TQ_I_CLOSED:  nxt_rdata = tq_i_closed_ff;
         dpo_pkg::OFS_CUR_P_OPEN:   nxt_rdata = cur_p_open_ff;
         dpo_pkg::OFS_CUR_I_OPEN:   nxt_rdata = cur_i_open_ff;
         dpo_pkg::OFS_SPEED_FF:     nxt_rdata = speed_ff_ff;
         dpo_pkg::OFS_ACCEL_FF:     nxt_rdata = accel_ff_ff;
         dpo_pkg::OFS_FLAGS_COUNT:  nxt_rdata = {24'h000000, dpo_pkg::RST_FLAGS_COUNT};
         dpo_pkg::OFS_FLAGS_SPARE:  nxt_rdata = {24'h000000, spare_ff};
         dpo_pkg::OFS_FIELD_INV:    nxt_rdata = {24'h000000, field_inv_ff};
         dpo_pkg::OFS_PRESERVE:     nxt_rdata = {24'h000000, preserve_ff};
         dpo_pkg::OFS_AIN_COUNT:    nxt_rdata = {24'h000000, dpo_pkg::RST_AIN_COUNT};
         dpo_pkg::OFS_AIN_ONE:      nxt_rdata = {16'h0000, ain_one_ff};
         dpo_pkg::OFS_AIN_TWO:      nxt_rdata = {16'h0000, ain_two_ff};
         dpo_pkg::OFS_SW_COUNT:     nxt_rdata = {24'h000000, dpo_pkg::RST_SW_COUNT};
         dpo_pkg::OFS_SW_POS:       nxt_rdata = {16'h0000, sw_pos_ff};
         dpo_pkg::OFS_FIELD_ACTIVE: nxt_rdata = {24'h000000, field_active_ff};
         dpo_pkg::OFS_ANALOG_MODE:  nxt_rdata = analog_mode_ff;
         default:                   nxt_rdata = 32'h00000000;
      endcase
   end

   // Read data valid only in the cycle after the read strobe
   always_ff @(posedge clk_sys_in)
   begin
      if (rst_in)
         rdata_out <= 32'h00000000;
      else if (rd_in)
         rdata_out <= nxt_rdata;
      else
         rdata_out <= 32'h00000000;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions
   // Reset values are checked one edge after reset is seen, so the first edge never sees X
   a_gain_reset_values: assert property (@(posedge clk_sys_in)
      rst_in |=> tq_p_closed_ff == 32'h000668a0 && tq_i_closed_ff == 32'h00002ee0)
      else $error("closed-loop gains not at reset value");

   a_open_gain_reset: assert property (@(posedge clk_sys_in)
      rst_in |=> cur_p_open_ff == 32'h0003a980 && cur_i_open_ff == 32'h0000afc8)
      else $error("open-loop gains not at reset value");

   a_ff_reset_values: assert property (@(posedge clk_sys_in)
      rst_in |=> speed_ff_ff == 32'h000003e8 && accel_ff_ff == 32'h00000000)
      else $error("feed-forward terms not at reset value");

   a_speed_ff_unity: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $past(rst_in, 2) |-> speed_ff_out == 32'h000003e8)
      else $error("speed feed-forward not unity after reset");

   a_accel_ff_enable: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !$past(rst_in) |-> accel_ff_enable_out == ($past(accel_ff_ff) != 32'h0))
      else $error("accel feed-forward enable wrong");

   a_field_held_run: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      $past(state_ff) != dpo_pkg::DPO_SAMPLE |-> $stable(field_active_ff))
      else $error("field direction changed outside restart");

   a_field_dir_map: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !$past(rst_in) && $past(field_active_ff) == 8'h05 |-> field_dir_out == 2'b00)
      else $error("illegal inversion code not treated as default");

   a_field_neg_dir: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !$past(rst_in) && $past(field_active_ff) == 8'hff |-> field_dir_out == 2'b10)
      else $error("negative inversion not forced");

   a_field_pos_dir: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !$past(rst_in) && $past(field_active_ff) == 8'h01 |-> field_dir_out == 2'b01)
      else $error("positive inversion not forced");

   a_field_default_dir: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !$past(rst_in) && $past(field_active_ff) == 8'h00 |-> field_dir_out == 2'b00)
      else $error("zero inversion code not firmware default");

   a_preserve_keeps: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      state_ff == dpo_pkg::DPO_SETUP && preserve_ff == 8'h01 && !wr_in
      |=> $stable(tq_p_closed_ff) && $stable(tq_i_closed_ff))
      else $error("preserved gains changed by auto setup");

   a_setup_loads: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      state_ff == dpo_pkg::DPO_SETUP && preserve_ff == 8'h00 && motor_is_stepper_in
      |=> tq_p_closed_ff == $past(stepper_tq_p_in))
      else $error("stepper preset not loaded");

   // Brushless preset must load both gains, not only the proportional one
   a_bldc_loads: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      state_ff == dpo_pkg::DPO_SETUP && preserve_ff == 8'h00 && !motor_is_stepper_in
      |=> tq_p_closed_ff == $past(bldc_tq_p_in) && tq_i_closed_ff == $past(bldc_tq_i_in))
      else $error("brushless preset not loaded");

   a_current_capable: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !$past(rst_in) && !$past(ain_current_capable_in[0])
      |-> !analog_one_current_select_out)
      else $error("current mode granted without hardware support");

   a_mode_two_select: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !$past(rst_in) |-> analog_two_current_select_out
         == ($past(analog_mode_ff[dpo_pkg::AIN_TWO_CUR_BIT]) && $past(ain_current_capable_in[1])))
      else $error("input two mode select wrong");

   a_switch_once: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      state_ff == dpo_pkg::DPO_IDLE && !restart_in |=> ##1 $stable(sw_pos_ff))
      else $error("switch position changed outside restart");

   a_analog_live: assert property (@(posedge clk_sys_in) disable iff (rst_in)
      !$past(rst_in) |-> ain_one_ff == $past(ain_one_in))
      else $error("analog value not tracking input");

endmodule : dpo_bank

`default_nettype wire

// ==== dpo_bank_tb.sv ====
// Self-checking testbench for the drive parameter object bank
`timescale 1ns/1ps
`default_nettype none

module dpo_bank_tb_top;
   // Clock, reset and stimulus
   logic        clk_sys_in = 1'b0;
   logic        rst_in     = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [31:0] wdata = 32'h00000000;
   logic        wr = 1'b0, rd = 1'b0, restart = 1'b0, as_start = 1'b0, stepper = 1'b1;
   logic [15:0] ain_one = 16'h8001, ain_two = 16'h03ff, sw = 16'h0000;
   logic [1:0]  capable = 2'b01;
   // Observed outputs
   logic [31:0] rdata_out, tq_p, tq_i, speed_ff;
   logic        sel_one, sel_two, busy, accel_en;
   logic [1:0]  field_dir;
   int          n_mismatch = 0;
   int          check_count = 0;
   logic [31:0] rv;

   dpo_bank dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata),
      .wr_in(wr), .rd_in(rd), .rdata_out(rdata_out), .restart_in(restart),
      .autosetup_start_in(as_start), .motor_is_stepper_in(stepper),
      .stepper_tq_p_in(32'h00011111), .stepper_tq_i_in(32'h00022222),
      .bldc_tq_p_in(32'h00033333), .bldc_tq_i_in(32'h00044444),
      .ain_one_in(ain_one), .ain_two_in(ain_two), .ain_current_capable_in(capable),
      .ain_switch_in(sw), .analog_one_current_select_out(sel_one),
      .analog_two_current_select_out(sel_two), .field_dir_out(field_dir),
      .autosetup_busy_out(busy), .tq_p_gain_out(tq_p), .tq_i_gain_out(tq_i),
      .speed_ff_out(speed_ff), .accel_ff_enable_out(accel_en));

   // 40 MHz system clock
   initial
   begin
      forever #12.5 clk_sys_in = ~clk_sys_in;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop();
      $display("Checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop

   task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk_sys_in);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk_sys_in);
      wr <= 1'b0;
   endtask : reg_wr

   // Read data stand only in the cycle after the strobe, so sample just past that edge
   task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
      @(posedge clk_sys_in);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk_sys_in);
      rd <= 1'b0;
      #1 d = rdata_out;
   endtask : reg_rd

   task automatic pulse_restart(input logic [15:0] sw_val);
      @(posedge clk_sys_in);
      sw      <= sw_val;
      restart <= 1'b1;
      @(posedge clk_sys_in);
      restart <= 1'b0;
      repeat (4) @(posedge clk_sys_in);
      #1;
   endtask : pulse_restart

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset_values();
      logic [15:0] ofs [12] = '{dpo_pkg::OFS_TQ_P_CLOSED, dpo_pkg::OFS_TQ_I_CLOSED,
         dpo_pkg::OFS_CUR_P_OPEN, dpo_pkg::OFS_CUR_I_OPEN, dpo_pkg::OFS_SPEED_FF,
         dpo_pkg::OFS_ACCEL_FF, dpo_pkg::OFS_FLAGS_COUNT, dpo_pkg::OFS_FIELD_INV,
         dpo_pkg::OFS_PRESERVE, dpo_pkg::OFS_AIN_COUNT, dpo_pkg::OFS_SW_COUNT,
         dpo_pkg::OFS_ANALOG_MODE};
      logic [31:0] exp [12] = '{32'h000668a0, 32'h00002ee0, 32'h0003a980, 32'h0000afc8,
         32'h000003e8, 32'h00000000, 32'h00000003, 32'h00000000, 32'h00000000,
         32'h00000002, 32'h00000001, 32'h00000000};
      check("tq_p_out", tq_p, 32'h000668a0);
      check("speed_ff_out", speed_ff, 32'h000003e8);
      check("accel_en", {31'h0, accel_en}, 32'h0);
      for (int i = 0; i < 12; i++)
      begin
         reg_rd(ofs[i], rv);
         check("reset_value", rv, exp[i]);
      end
   endtask : t_reset_values

   task automatic t_gains_rw();
      reg_wr(dpo_pkg::OFS_CUR_P_OPEN, 32'hfedcba98);
      reg_rd(dpo_pkg::OFS_CUR_P_OPEN, rv);
      check("open_p", rv, 32'hfedcba98);
      reg_wr(dpo_pkg::OFS_SPEED_FF, 32'h000001f4);
      reg_rd(dpo_pkg::OFS_SPEED_FF, rv);
      check("speed_ff", rv, 32'h000001f4);
      check("speed_ff_out", speed_ff, 32'h000001f4);
      reg_wr(dpo_pkg::OFS_ACCEL_FF, 32'h00000001);
      reg_rd(dpo_pkg::OFS_ACCEL_FF, rv);
      check("accel_en", {31'h0, accel_en}, 32'h1);
      reg_wr(dpo_pkg::OFS_FLAGS_COUNT, 32'h000000ff);
      reg_rd(dpo_pkg::OFS_FLAGS_COUNT, rv);
      check("flags_count_ro", rv, 32'h00000003);
      reg_rd(16'h0100, rv);
      check("unmapped", rv, 32'h00000000);
   endtask : t_gains_rw

   task automatic t_analog();
      reg_rd(dpo_pkg::OFS_AIN_ONE, rv);
      check("ain_one", rv, 32'h00008001);
      reg_wr(dpo_pkg::OFS_AIN_ONE, 32'h00001234);
      reg_rd(dpo_pkg::OFS_AIN_TWO, rv);
      check("ain_two_full_scale", rv, {16'h0, dpo_pkg::AIN_FULL_SCALE});
      reg_rd(dpo_pkg::OFS_AIN_ONE, rv);
      check("ain_one_ro", rv, 32'h00008001);
      reg_wr(dpo_pkg::OFS_ANALOG_MODE, 32'h00000003);
      reg_rd(dpo_pkg::OFS_ANALOG_MODE, rv);
      check("sel_one", {31'h0, sel_one}, 32'h1);
      check("sel_two_not_capable", {31'h0, sel_two}, 32'h0);
      @(posedge clk_sys_in);
      capable <= 2'b10;
      reg_wr(dpo_pkg::OFS_ANALOG_MODE, 32'h00000002);
      reg_rd(dpo_pkg::OFS_ANALOG_MODE, rv);
      check("mode_word", rv, 32'h00000002);
      check("sel_one_voltage", {31'h0, sel_one}, 32'h0);
      check("sel_two", {31'h0, sel_two}, 32'h1);
   endtask : t_analog

   // Field direction and switch position only move at a restart
   task automatic t_field_and_switch();
      logic [7:0]  code [4] = '{8'h01, 8'hff, 8'h05, 8'h00};
      logic [1:0]  dir  [4] = '{2'b01, 2'b10, 2'b00, 2'b00};
      for (int i = 0; i < 4; i++)
      begin
         reg_wr(dpo_pkg::OFS_FIELD_INV, {24'h0, code[i]});
         repeat (4) @(posedge clk_sys_in);
         check("dir_before_restart", {30'h0, field_dir}, {30'h0, dir[(i + 3) % 4]});
         pulse_restart(16'h00a5 + 16'(i));
         check("dir_after_restart", {30'h0, field_dir}, {30'h0, dir[i]});
         @(posedge clk_sys_in);
         sw <= 16'h5a00;
         reg_rd(dpo_pkg::OFS_SW_POS, rv);
         check("switch_held", rv, 32'h000000a5 + 32'(i));
      end
   endtask : t_field_and_switch

   task automatic auto_setup(input logic st, input logic [31:0] ep, input logic [31:0] ei);
      int n;
      @(posedge clk_sys_in);
      stepper  <= st;
      as_start <= 1'b1;
      @(posedge clk_sys_in);
      as_start <= 1'b0;
      for (n = 0; n < 20; n++)
      begin
         @(posedge clk_sys_in);
         #1;
         if (busy === 1'b1)
            break;
      end
      if (n == 20)
      begin
         n_mismatch++;
         $display("ERROR autosetup_busy expected 1 seen %b", busy);
         report_and_stop();
      end
      @(posedge clk_sys_in);
      #1;
      check("tq_p_out", tq_p, ep);
      check("tq_i_out", tq_i, ei);
      reg_rd(dpo_pkg::OFS_TQ_P_CLOSED, rv);
      check("tq_p_reg", rv, ep);
      reg_rd(dpo_pkg::OFS_TQ_I_CLOSED, rv);
      check("tq_i_reg", rv, ei);
   endtask : auto_setup

   task automatic t_auto_setup();
      auto_setup(1'b1, 32'h00011111, 32'h00022222);
      auto_setup(1'b0, 32'h00033333, 32'h00044444);
      reg_wr(dpo_pkg::OFS_PRESERVE, 32'h00000001);
      reg_wr(dpo_pkg::OFS_TQ_P_CLOSED, 32'h00001234);
      reg_wr(dpo_pkg::OFS_TQ_I_CLOSED, 32'h00005678);
      auto_setup(1'b1, 32'h00001234, 32'h00005678);
   endtask : t_auto_setup

   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk_sys_in);
      rst_in <= 1'b0;
      @(posedge clk_sys_in);
      #1;
      t_reset_values();
      t_gains_rw();
      t_analog();
      t_field_and_switch();
      t_auto_setup();
      report_and_stop();
   end
endmodule : dpo_bank_tb_top

`default_nettype wire
